/* File: paired_timer_consts.svh */
// constants for the paired 32-bit timer: offsets, field positions, resets
// assumes inclusion by bare name from the package only; the timer files get the macros through it
`ifndef PAIRED_TIMER_CONSTS_SVH
`define PAIRED_TIMER_CONSTS_SVH
`define PT_ADR_LOW_CTRL 4'h0
`define PT_ADR_HIGH_CTRL 4'h1
`define PT_ADR_LOW_PERIOD 4'h2
`define PT_ADR_HIGH_PERIOD 4'h3
`define PT_ADR_LOW_COUNT 4'h4
`define PT_ADR_HIGH_COUNT 4'h5
`define PT_ADR_STATUS 4'h6
`define PT_ADR_IDLE 4'h7
`define PT_BIT_RUN 15
`define PT_BIT_IDLE_STOP 13
`define PT_BIT_GATE 6
`define PT_BIT_PS_HI 5
`define PT_BIT_PS_LO 4
`define PT_BIT_PAIR 3
`define PT_BIT_CLK_SRC 1
`define PT_LOW_CTRL_MASK 16'ha07a
`define PT_HIGH_CTRL_MASK 16'ha072
`define PT_CTRL_RESET 16'h0000
`define PT_PERIOD_RESET 16'hffff
`define PT_COUNT_RESET 16'h0000
`define PT_PS_DIV1 2'h0
`define PT_PS_DIV8 2'h1
`define PT_PS_DIV64 2'h2
`define PT_PS_DIV256 2'h3
`define PT_PS_MAX8 8'h07
`define PT_PS_MAX64 8'h3f
`define PT_PS_MAX256 8'hff
`endif

/* File: paired_timer_pkg.sv */
// types shared by the paired timer files
// assumes paired_timer_consts.svh sits in the same folder
package paired_timer_pkg;
  `include "paired_timer_consts.svh"
  // decoded control fields of one timer
  typedef struct packed {
    logic run;
    logic idle_stop;
    logic gate;
    logic [1:0] prescale;
    logic clk_src;
  } timer_ctrl_type;
  // time bases offered to capture, compare and converter logic
  typedef struct packed {
    logic [15:0] low_count;
    logic [15:0] high_count;
    logic low_tick;
    logic high_tick;
    logic pair_mode;
  } time_base_type;
endpackage : paired_timer_pkg

/* File: timer_lane.sv */
// one 16-bit timer lane: prescaler, gate, edge detect and clock enable
// assumes synchronous pin inputs; emits one-cycle count enables
`timescale 1ns/100ps
module timer_lane
  import paired_timer_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire timer_ctrl_type ctrl_i,
  input wire logic halt_i,
  input wire logic ext_clk_i,
  input wire logic gate_i,
  input wire logic clear_ps_i,
  output logic tick_o,
  output logic gate_fall_o
);
  logic [7:0] ps_cnt_r;
  logic ext_d_r;
  logic gate_d_r;
  logic [7:0] ps_max;
  logic raw_tick;
  logic gated;
  // gate only meaningful with internal clock
  assign gated = ctrl_i.gate & ~ctrl_i.clk_src;
  // prescale division ratio
  always_comb begin
    case (ctrl_i.prescale)
      `PT_PS_DIV8: ps_max = `PT_PS_MAX8;
      `PT_PS_DIV64: ps_max = `PT_PS_MAX64;
      `PT_PS_DIV256: ps_max = `PT_PS_MAX256;
      default: ps_max = 8'h00;
    endcase
  end
  // input event: rising pin edge, or every internal clock while ungated or gate pin high
  always_comb begin
    if (ctrl_i.clk_src) begin
      raw_tick = ext_clk_i & ~ext_d_r;
    end else begin
      raw_tick = ~gated | gate_i;
    end
  end
  // pin history for edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_d_r <= 1'b0;
      gate_d_r <= 1'b0;
    end else begin
      ext_d_r <= ext_clk_i;
      gate_d_r <= gate_i;
    end
  end
  // prescale counter
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_ps_i || !ctrl_i.run) begin
      ps_cnt_r <= 8'h00;
    end else if (raw_tick && !halt_i) begin
      if (ps_cnt_r >= ps_max) begin
        ps_cnt_r <= 8'h00;
      end else begin
        ps_cnt_r <= ps_cnt_r + 8'h01;
      end
    end
  end
  assign tick_o = ctrl_i.run & ~halt_i & raw_tick & (ps_cnt_r >= ps_max);
  // gate falling edge ends an accumulation
  assign gate_fall_o = ctrl_i.run & gated & gate_d_r & ~gate_i;
endmodule : timer_lane

/* File: paired_timer_32bit.sv */
// paired 16-bit timers, chainable into one 32-bit timer, wishbone slave
// assumes classic wishbone master, synchronous pins, one 50 MHz clock
//
// Behaviour
// - pair mode bit 3 of low control chains both timers into 32 bits
// - in pair mode low timer is lsw, high timer is msw
// - in pair mode high control run, gate, prescale, source are ignored
// - pair mode uses low timer clock and gate, flags via high timer flag
// - pair mode compares against high:low period, flags on match
// - running 32-bit count lives in high and low count registers
// - run bit 15 starts or stops timer; low bit drives pair
// - idle stop bit 13 halts timer in idle, else it keeps running
// - gate accumulate bit 6 acts only with internal clock
// - prescale bits 5-4 divide by 256, 64, 8 or 1
// - low clock source bit 1 picks pin rising edges or internal clock
// - high clock source picks internal clock or its own pin
// - timers are synchronous only, no asynchronous counting
// - both timers are time bases; converter trigger only in pair mode
// - unimplemented control bits read as zero
`timescale 1ns/100ps
module paired_timer_32bit
  import paired_timer_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic idle_i,
  input wire logic low_ext_clock_pin_i,
  input wire logic high_ext_clock_pin_i,
  output time_base_type time_base_o,
  output logic low_timer_flag_o,
  output logic high_timer_flag_o,
  output logic converter_trigger_o
);
  logic [15:0] low_ctrl_r;
  logic [15:0] high_ctrl_r;
  logic [15:0] low_period_r;
  logic [15:0] high_period_r;
  logic [15:0] low_count_r;
  logic [15:0] high_count_r;
  logic low_flag_r;
  logic high_flag_r;
  logic trig_r;
  logic ack_r;
  logic [31:0] rd_data_r;
  logic pair_mode;
  timer_ctrl_type low_ctrl;
  timer_ctrl_type high_ctrl;
  logic low_halt;
  logic high_halt;
  logic low_tick;
  logic high_tick_lane;
  logic high_tick;
  logic low_gfall;
  logic high_gfall;
  logic low_match;
  logic high_match;
  logic pair_match;
  logic [31:0] pair_count;
  logic [31:0] pair_period;
  logic wr_req;
  logic [3:0] reg_idx;
  logic wr_low_count;
  logic wr_high_count;
  logic wr_status;

  // decode the control word into fields
  function automatic timer_ctrl_type decode_ctrl(input logic [15:0] w);
    timer_ctrl_type c;
    c.run = w[`PT_BIT_RUN];
    c.idle_stop = w[`PT_BIT_IDLE_STOP];
    c.gate = w[`PT_BIT_GATE];
    c.prescale = w[`PT_BIT_PS_HI:`PT_BIT_PS_LO];
    c.clk_src = w[`PT_BIT_CLK_SRC];
    return c;
  endfunction : decode_ctrl

  // masked byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [15:0] nw,
                                           input logic [1:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = nw[7:0];
    end
    if (sel[1]) begin
      r[15:8] = nw[15:8];
    end
    return r;
  endfunction : merge16

  assign pair_mode = low_ctrl_r[`PT_BIT_PAIR];
  assign low_ctrl = decode_ctrl(low_ctrl_r);
  // in pair mode the high lane is idle; only its idle stop bit still acts
  always_comb begin
    high_ctrl = decode_ctrl(high_ctrl_r);
    if (pair_mode) begin
      high_ctrl.run = 1'b0;
    end
  end
  // idle stop; pair mode halts if either idle stop bit is set
  assign low_halt = idle_i & (low_ctrl.idle_stop |
                    (pair_mode & high_ctrl_r[`PT_BIT_IDLE_STOP]));
  assign high_halt = idle_i & high_ctrl.idle_stop;

  // low lane clocks the pair as well
  timer_lane u_low_lane (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ctrl_i(low_ctrl),
    .halt_i(low_halt),
    .ext_clk_i(low_ext_clock_pin_i),
    .gate_i(low_ext_clock_pin_i),
    .clear_ps_i(wr_low_count),
    .tick_o(low_tick),
    .gate_fall_o(low_gfall)
  );

  timer_lane u_high_lane (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ctrl_i(high_ctrl),
    .halt_i(high_halt),
    .ext_clk_i(high_ext_clock_pin_i),
    .gate_i(high_ext_clock_pin_i),
    .clear_ps_i(wr_high_count),
    .tick_o(high_tick_lane),
    .gate_fall_o(high_gfall)
  );

  assign high_tick = pair_mode ? low_tick : high_tick_lane;
  // period comparisons
  assign pair_count = {high_count_r, low_count_r};
  assign pair_period = {high_period_r, low_period_r};
  assign pair_match = (pair_count == pair_period);
  assign low_match = (low_count_r == low_period_r);
  assign high_match = (high_count_r == high_period_r);

  // bus decode: one aligned word per register
  assign reg_idx = wb_adr_i[5:2];
  assign wr_req = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r;
  assign wr_low_count = wr_req & (reg_idx == `PT_ADR_LOW_COUNT);
  assign wr_high_count = wr_req & (reg_idx == `PT_ADR_HIGH_COUNT);
  assign wr_status = wr_req & (reg_idx == `PT_ADR_STATUS);

  // control registers keep only implemented bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_ctrl_r <= `PT_CTRL_RESET;
      high_ctrl_r <= `PT_CTRL_RESET;
    end else if (wr_req && reg_idx == `PT_ADR_LOW_CTRL) begin
      low_ctrl_r <= merge16(low_ctrl_r, wb_dat_i[15:0], wb_sel_i[1:0]) &
                    `PT_LOW_CTRL_MASK;
    end else if (wr_req && reg_idx == `PT_ADR_HIGH_CTRL) begin
      high_ctrl_r <= merge16(high_ctrl_r, wb_dat_i[15:0], wb_sel_i[1:0]) &
                     `PT_HIGH_CTRL_MASK;
    end
  end

  // period registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_period_r <= `PT_PERIOD_RESET;
      high_period_r <= `PT_PERIOD_RESET;
    end else if (wr_req && reg_idx == `PT_ADR_LOW_PERIOD) begin
      low_period_r <= merge16(low_period_r, wb_dat_i[15:0], wb_sel_i[1:0]);
    end else if (wr_req && reg_idx == `PT_ADR_HIGH_PERIOD) begin
      high_period_r <= merge16(high_period_r, wb_dat_i[15:0], wb_sel_i[1:0]);
    end
  end

  // low count: bus write wins, else counts on its tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_count_r <= `PT_COUNT_RESET;
    end else if (wr_low_count) begin
      low_count_r <= merge16(low_count_r, wb_dat_i[15:0], wb_sel_i[1:0]);
    end else if (low_tick) begin
      if (pair_mode ? pair_match : low_match) begin
        low_count_r <= `PT_COUNT_RESET;
      end else begin
        low_count_r <= low_count_r + 16'h0001;
      end
    end
  end

  // high count: carries from low in pair mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_count_r <= `PT_COUNT_RESET;
    end else if (wr_high_count) begin
      high_count_r <= merge16(high_count_r, wb_dat_i[15:0], wb_sel_i[1:0]);
    end else if (pair_mode) begin
      if (low_tick && pair_match) begin
        high_count_r <= `PT_COUNT_RESET;
      end else if (low_tick && low_count_r == 16'hffff) begin
        high_count_r <= high_count_r + 16'h0001;
      end
    end else if (high_tick) begin
      if (high_match) begin
        high_count_r <= `PT_COUNT_RESET;
      end else begin
        high_count_r <= high_count_r + 16'h0001;
      end
    end
  end

  // sticky flags; a new event wins over a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_flag_r <= 1'b0;
      high_flag_r <= 1'b0;
    end else begin
      if ((!pair_mode && ((low_tick && low_match) || low_gfall))) begin
        low_flag_r <= 1'b1;
      end else if (wr_status && wb_sel_i[0] && wb_dat_i[0]) begin
        low_flag_r <= 1'b0;
      end
      if ((pair_mode && ((low_tick && pair_match) || low_gfall)) ||
          (!pair_mode && ((high_tick && high_match) || high_gfall))) begin
        high_flag_r <= 1'b1;
      end else if (wr_status && wb_sel_i[0] && wb_dat_i[1]) begin
        high_flag_r <= 1'b0;
      end
    end
  end

  // converter trigger pulse from the combined timer only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_r <= 1'b0;
    end else begin
      trig_r <= pair_mode & low_tick & pair_match;
    end
  end

  // read mux, answered one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_r <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !ack_r) begin
      case (reg_idx)
        `PT_ADR_LOW_CTRL: rd_data_r <= {16'h0000, low_ctrl_r};
        `PT_ADR_HIGH_CTRL: rd_data_r <= {16'h0000, high_ctrl_r};
        `PT_ADR_LOW_PERIOD: rd_data_r <= {16'h0000, low_period_r};
        `PT_ADR_HIGH_PERIOD: rd_data_r <= {16'h0000, high_period_r};
        `PT_ADR_LOW_COUNT: rd_data_r <= {16'h0000, low_count_r};
        `PT_ADR_HIGH_COUNT: rd_data_r <= {16'h0000, high_count_r};
        `PT_ADR_STATUS: rd_data_r <= {29'h0, pair_mode, high_flag_r,
                                      low_flag_r};
        `PT_ADR_IDLE: rd_data_r <= {31'h0, idle_i};
        default: rd_data_r <= 32'h0000_0000;
      endcase
    end
  end

  // ack one cycle after strobe, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rd_data_r;
  assign low_timer_flag_o = low_flag_r;
  assign high_timer_flag_o = high_flag_r;
  assign converter_trigger_o = trig_r;
  // both counts offered as time bases
  assign time_base_o = '{low_count: low_count_r, high_count: high_count_r,
                         low_tick: low_tick, high_tick: high_tick,
                         pair_mode: pair_mode};
endmodule : paired_timer_32bit

/* File: paired_timer_32bit_monitor.sv */
// checker on the paired timer ports: bus answer, counting, pair match
// assumes bind from the bench top, one clock, sync active-high reset
`timescale 1ns/100ps
module paired_timer_32bit_monitor
  import paired_timer_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic wb_ack_o,
  input wire time_base_type time_base_o,
  input wire logic high_timer_flag_o,
  input wire logic converter_trigger_o
);
  logic take;
  logic wlo;
  logic whi;
  // bus writes that overwrite a count at the taking edge
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wlo = take && wb_we_i && (wb_adr_i[5:2] == 4'h4);
  assign whi = take && wb_we_i && (wb_adr_i[5:2] == 4'h5);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_next_cycle: assert property (take |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(take))
    else $error("ack without request");
  a_trig_pair_only: assert property (
    converter_trigger_o |-> time_base_o.pair_mode)
    else $error("trigger outside pair mode");
  a_trig_high_flag: assert property (
    converter_trigger_o |-> high_timer_flag_o)
    else $error("pair match without high flag");
  a_trig_counts_zero: assert property (
    converter_trigger_o |-> time_base_o.low_count == 16'h0 &&
    time_base_o.high_count == 16'h0)
    else $error("counts not cleared at match");
  a_low_count_step: assert property (
    !$past(rst_i) && $past(time_base_o.low_tick) && !$past(wlo) |->
    time_base_o.low_count == $past(time_base_o.low_count) + 16'h1 ||
    time_base_o.low_count == 16'h0)
    else $error("low count did not step");
  a_low_count_hold: assert property (
    !$past(rst_i) && !$past(time_base_o.low_tick) && !$past(wlo) |->
    $stable(time_base_o.low_count))
    else $error("low count moved without tick");
  a_high_carry_in: assert property (
    !$past(rst_i) && $past(time_base_o.pair_mode &&
    time_base_o.low_tick && time_base_o.low_count == 16'hffff) &&
    !$past(whi) |->
    time_base_o.high_count == $past(time_base_o.high_count) + 16'h1 ||
    time_base_o.high_count == 16'h0)
    else $error("high word missed carry");
endmodule : paired_timer_32bit_monitor

/* File: time_base_user_model.sv */
// far-side model: converter that starts one conversion per trigger
// assumes a one-cycle registered trigger pulse from the timer block
`timescale 1ns/100ps
module time_base_user_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic trigger_i,
  output logic [7:0] trigger_count_o
);
  // every pulse starts a conversion, whatever the mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trigger_count_o <= 8'h00;
    end else if (trigger_i) begin
      trigger_count_o <= trigger_count_o + 8'h01;
    end
  end
endmodule : time_base_user_model

/* File: paired_timer_32bit_tb_top.sv */
// bench for the paired timer: wishbone master tasks, one task a case
// assumes the design, its package and the converter model alongside
`timescale 1ns/100ps
module paired_timer_32bit_tb_top;
  import paired_timer_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, idle, lpin, hpin, ack, lf, hf, trig;
  logic [5:0] adr;
  logic [31:0] dat_w, dat_r;
  logic [7:0] trig_n;
  time_base_type tb;
  int errors, checks, n;
  always #10 clk_i = ~clk_i;
  paired_timer_32bit paired_timer_32bit_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h3), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .idle_i(idle), .low_ext_clock_pin_i(lpin),
    .high_ext_clock_pin_i(hpin), .time_base_o(tb),
    .low_timer_flag_o(lf), .high_timer_flag_o(hf),
    .converter_trigger_o(trig));
  time_base_user_model time_base_user_model_i (.clk_i(clk_i),
    .rst_i(rst_i), .trigger_i(trig), .trigger_count_o(trig_n));
  task check(input string what, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask : check
  // one classic cycle, held until ack is sampled high
  task xfer(input logic [3:0] i, input logic w, input logic [15:0] d,
            output logic [15:0] q);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {i, 2'h0};
    dat_w <= {16'h0, d};
    k = 0;
    // ack and read data are taken as sampled at the rising edge
    do begin @(posedge clk_i); k++; end while (ack !== 1'b1 && k < 50);
    if (ack !== 1'b1) errors++;
    q = dat_r[15:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : xfer
  task wr(input logic [3:0] i, input logic [15:0] d);
    logic [15:0] q;
    xfer(i, 1'b1, d, q);
  endtask : wr
  task rd(input string what, input logic [3:0] i, input logic [15:0] e);
    logic [15:0] q;
    xfer(i, 1'b0, 16'h0, q);
    check(what, q, e);
  endtask : rd
  task ticks(input int c);
    n = 0;
    repeat (c) begin @(negedge clk_i); if (tb.low_tick === 1'b1) n++; end
  endtask : ticks
  task wait_on(input int sel);
    int k;
    k = 0;
    while (k < 200 && (sel ? trig : lf) !== 1'b1) begin
      @(negedge clk_i); k++;
    end
    if (k >= 200) errors++;
  endtask : wait_on
  // reset values, unmapped index, unimplemented control bits
  task t_regs;
    for (int i = 0; i < 9; i++) begin
      if (i < 6 || i == 8) begin
        rd("reset", 4'(i), (i == 2 || i == 3) ? 16'hffff : 16'h0000);
      end
    end
    wr(0, 16'hffff); rd("low ctrl", 0, 16'ha07a);
    wr(0, 16'h0); wr(1, 16'hffff); rd("high ctrl", 1, 16'ha072);
    wr(1, 16'h0);
  endtask : t_regs
  // tick rate for each prescale code over a 512-cycle window
  task t_prescale;
    for (int c = 0; c < 4; c++) begin
      wr(0, 16'h8000 | 16'(c << 4)); ticks(512);
      check("prescale", n, 512 >> (c == 0 ? 0 : c == 3 ? 8 : 3 * c));
      wr(0, 16'h0);
    end
  endtask : t_prescale
  // 16-bit period match: count to zero, low flag, no trigger
  task t_period;
    wr(6, 16'h3); wr(4, 16'h0); wr(2, 16'h5);
    wr(0, 16'h8000); wait_on(0);
    check("low at match", tb.low_count, 16'h0);
    check("low flag", lf, 1'b1);
    check("no trigger", trig_n, 8'h0);
    wr(0, 16'h0);
  endtask : t_period
  // 32-bit chain across the word boundary, high fields ignored
  task t_pair;
    wr(6, 16'h3); wr(0, 16'h0008); wr(1, 16'h8032);
    wr(2, 16'h3); wr(3, 16'h1); wr(5, 16'h0); wr(4, 16'hfffc);
    wr(0, 16'h8008); wait_on(1);
    check("pair counts", {tb.high_count, tb.low_count}, 0);
    check("flags", {hf, lf}, 2'h2);
    check("pair out", tb.pair_mode, 1'b1);
    rd("status", 6, 16'h6);
    check("one trigger", trig_n, 8'h1);
    // back to free-running periods so later lanes never match early
    wr(0, 16'h0); wr(1, 16'h0); wr(2, 16'hffff); wr(3, 16'hffff);
  endtask : t_pair
  // external edges on the high pin, idle stop, gated accumulation
  task t_pins;
    wr(5, 16'h0); wr(1, 16'h8002); n = 0;
    // one pin pulse per pass, high tick seen mid-cycle
    repeat (4) begin
      @(posedge clk_i) hpin <= 1'b1;
      @(negedge clk_i) if (tb.high_tick === 1'b1) n++;
      @(posedge clk_i) hpin <= 1'b0;
    end
    repeat (4) @(posedge clk_i);
    check("high tick out", n, 4);
    rd("high edges", 5, 16'h4); wr(1, 16'h0);
    @(posedge clk_i) idle <= 1'b1;
    wr(0, 16'ha000); ticks(64); check("idle stop", n, 0);
    wr(0, 16'h8000); ticks(64); check("idle run", n, 64);
    // pair in idle: high idle stop must be clear for it to run
    wr(1, 16'h2000); wr(0, 16'h8008); ticks(64);
    check("pair idle stop", n, 0);
    wr(1, 16'h0); ticks(64); check("pair idle run", n, 64);
    wr(0, 16'h0); wr(6, 16'h3); wr(0, 16'h8040); n = 0;
    for (int k = 0; k < 40; k++) begin
      @(posedge clk_i) lpin <= (k >= 5 && k < 15);
      @(negedge clk_i) if (tb.low_tick === 1'b1) n++;
    end
    check("gated", n, 10); check("gate flag", lf, 1'b1);
    wr(0, 16'h0);
  endtask : t_pins
  task tally_and_finish;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  // watchdog well past the longest sequence
  initial begin
    repeat (40000) @(posedge clk_i);
    errors++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    clk_i = 0; rst_i = 1; cyc = 0; stb = 0; we = 0; adr = 0; dat_w = 0;
    idle = 0; lpin = 0; hpin = 0; errors = 0; checks = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs(); t_prescale(); t_period(); t_pair(); t_pins();
    tally_and_finish();
  end
endmodule : paired_timer_32bit_tb_top
bind paired_timer_32bit paired_timer_32bit_monitor
  paired_timer_32bit_monitor_i (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .time_base_o(time_base_o),
  .high_timer_flag_o(high_timer_flag_o),
  .converter_trigger_o(converter_trigger_o));
